// [adcsc_pkg.sv]
// adcsc_pkg: constants, encodings and decode helpers of the sleep-aware
// converter controller.
// assumes every user writes adcsc_pkg::name, nothing is imported.
package adcsc_pkg;

    // result layout
    localparam int RES_W = 10;
    localparam int BYTE_W = 8;
    localparam int LEFT_PAD_W = 6;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] MID_CODE = 10'h200;
    localparam logic [3:0] MSB_IDX = 4'h9;

    // control reset values
    localparam logic [1:0] REF_RST = 2'h0;
    localparam logic [4:0] CHAN_RST = 5'h00;

    // conversion timing in converter clock cycles
    localparam logic [3:0] SAMPLE_CYC = 4'h2;
    localparam logic [3:0] FIRST_EXTRA_CYC = 4'hc;
    localparam int NORMAL_CONV_CYC = 13;
    localparam int FIRST_CONV_CYC = 25;

    // channel codes that select a differential pair
    localparam logic [4:0] MUX_DIFF_LO = 5'h08;
    localparam logic [4:0] MUX_DIFF_HI = 5'h1d;

    typedef enum logic [1:0]
    {
        REF_EXT_PIN = 2'b00,
        REF_ANALOG_SUPPLY = 2'b01,
        REF_INT_1V1 = 2'b10,
        REF_INT_2V56 = 2'b11
    } adcsc_ref_e;

    // sleep controller mode code, sampled together with the halt level
    typedef enum logic [2:0]
    {
        SLP_IDLE = 3'b000,
        SLP_NOISE_RED = 3'b001,
        SLP_POWER_DOWN = 3'b010,
        SLP_POWER_SAVE = 3'b011,
        SLP_STANDBY = 3'b110,
        SLP_EXT_STANDBY = 3'b111
    } adcsc_sleep_e;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_INIT = 3'b001,
        ST_SYNC = 3'b010,
        ST_SAMPLE = 3'b011,
        ST_CONVERT = 3'b100,
        ST_DONE = 3'b101
    } adcsc_state_e;

    // true for channel codes that route a differential pair
    function automatic logic adcsc_is_diff(input logic [4:0] sel);
        adcsc_is_diff = (sel >= MUX_DIFF_LO) && (sel <= MUX_DIFF_HI);
    endfunction : adcsc_is_diff

endpackage : adcsc_pkg

// [adcsc_conv_if.sv]
// adcsc_conv_if: carrier between the sequencer, the successive
// approximation engine and the result formatter.
// assumes one clock and one active-low asynchronous reset for all ends.
`timescale 1ns/1ps
interface adcsc_conv_if (input wire logic mclk, input wire logic nrst);
    logic sar_start;
    logic sar_abort;
    logic sar_cmp;
    logic sar_done;
    logic [9:0] sar_trial;
    logic [9:0] sar_code;
    logic diff_sel;
    logic [9:0] mapped_code;
    logic [9:0] stored;
    logic left_adj;
    logic [7:0] low_byte;
    logic [7:0] high_byte;

    modport ctl (input mclk, nrst, sar_done, sar_trial, sar_code, mapped_code,
        low_byte, high_byte, output sar_start, sar_abort, sar_cmp, diff_sel,
        stored, left_adj);
    modport sar (input mclk, nrst, sar_start, sar_abort, sar_cmp,
        output sar_done, sar_trial, sar_code);
    modport fmt (input mclk, nrst, sar_code, diff_sel, stored, left_adj,
        output mapped_code, low_byte, high_byte);
endinterface : adcsc_conv_if

// [adcsc_sar.sv]
// adcsc_sar: ten-step successive approximation, msb first.
// assumes the comparator answers within the same cycle as the trial code.
`timescale 1ns/1ps
module adcsc_sar (adcsc_conv_if.sar bus);

    logic [9:0] trial;
    logic [9:0] next_trial;
    logic [9:0] code;
    logic [9:0] next_code;
    logic [3:0] idx;
    logic [3:0] next_idx;
    logic busy;
    logic next_busy;

    // bit trials; comparator high means input is at or above the trial
    always_comb
    begin
        next_trial = trial;
        next_code = code;
        next_idx = idx;
        next_busy = busy;
        if (bus.sar_abort)
        begin
            next_busy = 1'b0;
            next_trial = adcsc_pkg::RESULT_RST;
        end
        else if (bus.sar_start)
        begin
            next_busy = 1'b1;
            next_trial = adcsc_pkg::MID_CODE;
            next_idx = adcsc_pkg::MSB_IDX;
        end
        else if (busy)
        begin
            next_trial[idx] = bus.sar_cmp;
            if (idx == 4'h0)
            begin
                next_busy = 1'b0;
                next_code = next_trial;
            end
            else
            begin
                next_idx = 4'(idx - 4'h1);
                next_trial[next_idx] = 1'b1;
            end
        end
    end

    always_ff @(posedge bus.mclk or negedge bus.nrst)
    begin
        if (!bus.nrst)
        begin
            trial <= 10'h000;
            code <= 10'h000;
            idx <= 4'h0;
            busy <= 1'b0;
        end
        else
        begin
            trial <= next_trial;
            code <= next_code;
            idx <= next_idx;
            busy <= next_busy;
        end
    end

    assign bus.sar_done = busy && (idx == 4'h0);
    assign bus.sar_trial = trial;
    assign bus.sar_code = code;

    default clocking cb @(posedge bus.mclk);
    endclocking
    default disable iff (!bus.nrst);

    a_sar_msb_first: assert property (
        (bus.sar_start && !bus.sar_abort) |=> (trial == adcsc_pkg::MID_CODE))
        else $error("trial does not open at mid code");
    a_sar_ten_steps: assert property (
        (bus.sar_start && !bus.sar_abort) |-> ##10 (bus.sar_done || !busy))
        else $error("approximation not ten cycles long");
endmodule : adcsc_sar

// [adcsc_fmt.sv]
// adcsc_fmt: maps the raw code to unsigned or two's complement and lays
// the stored result across the two result bytes.
// assumes the raw code is offset binary, mid code meaning zero difference.
`timescale 1ns/1ps
module adcsc_fmt (adcsc_conv_if.fmt bus);

    // offset binary to two's complement is an msb flip, so the range ends
    // saturate by construction
    always_comb
    begin
        bus.mapped_code = bus.sar_code;
        if (bus.diff_sel)
        begin
            bus.mapped_code = {~bus.sar_code[9], bus.sar_code[8:0]};
        end
    end

    // live justification, so the adjust control acts at once
    always_comb
    begin
        if (bus.left_adj)
        begin
            bus.high_byte = bus.stored[9:2];
            bus.low_byte = {bus.stored[1:0], {adcsc_pkg::LEFT_PAD_W{1'b0}}};
        end
        else
        begin
            bus.high_byte = {{adcsc_pkg::LEFT_PAD_W{1'b0}}, bus.stored[9:8]};
            bus.low_byte = bus.stored[7:0];
        end
    end

    default clocking cb @(posedge bus.mclk);
    endclocking
    default disable iff (!bus.nrst);

    a_diff_zero_code: assert property (
        (bus.diff_sel && bus.sar_code == adcsc_pkg::MID_CODE)
        |-> (bus.mapped_code == 10'h000))
        else $error("zero difference not coded as zero");
    a_sign_in_high: assert property (
        bus.left_adj ? (bus.high_byte[7] == bus.stored[9])
                     : (bus.high_byte[1] == bus.stored[9]))
        else $error("sign bit misplaced in high byte");
endmodule : adcsc_fmt

// [adcsc_top.sv]
// adcsc_top: conversion sequencer with sleep-time start, done flag and
// result register of a 10-bit successive approximation converter.
// assumes control inputs are synchronous to mclk_i, which is the
// prescaled converter clock; the comparator answers combinationally.
`timescale 1ns/1ps

module adcsc_top
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // control bits written by software
    input wire logic conv_enable_i,
    input wire logic conv_start_we_i,
    input wire logic conv_start_wd_i,
    input wire logic single_mode_i,
    input wire logic conv_done_ie_i,
    input wire logic conv_done_clr_i,
    input wire logic result_left_adjust_i,
    input wire logic [1:0] reference_select_i,
    input wire logic [4:0] channel_gain_select_i,
    // sleep controller
    input wire logic cpu_halted_i,
    input wire logic [2:0] sleep_mode_i,
    // analog converter
    input wire logic cmp_i,
    output logic analog_on_o,
    output logic sample_o,
    output logic [9:0] dac_code_o,
    output logic [3:0] ref_route_o,
    output logic [4:0] chan_sel_o,
    // status and result
    output logic conv_start_o,
    output logic conv_done_flag_o,
    output logic conv_irq_o,
    output logic [7:0] result_low_byte_o,
    output logic [7:0] result_high_byte_o,
    output logic result_sign_bit_o
);

    adcsc_pkg::adcsc_state_e state;
    adcsc_pkg::adcsc_state_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic first;
    logic next_first;
    logic en_q;
    logic halt_q;
    logic clk2;
    logic done_flag;
    logic next_done_flag;
    logic [9:0] result;
    logic [9:0] next_result;
    logic [1:0] ref_q;
    logic [1:0] next_ref;
    logic [4:0] chan_q;
    logic [4:0] next_chan;
    logic sw_start;
    logic sleep_qual;
    logic halt_rise;
    logic sleep_start;
    logic start_req;
    logic diff_now;

    adcsc_conv_if bus (.mclk(mclk_i), .nrst(nrst_i));

    adcsc_sar u_sar (.bus(bus.sar));
    adcsc_fmt u_fmt (.bus(bus.fmt));

    // start requests; a zero written to start is simply not a request
    always_comb
    begin
        sw_start = conv_start_we_i && conv_start_wd_i;
        sleep_qual = (sleep_mode_i == adcsc_pkg::SLP_NOISE_RED)
            || (sleep_mode_i == adcsc_pkg::SLP_IDLE);
        halt_rise = cpu_halted_i && !halt_q;
        sleep_start = halt_rise && sleep_qual && single_mode_i;
        start_req = conv_enable_i && (state == adcsc_pkg::ST_IDLE)
            && (sw_start || sleep_start);
        diff_now = adcsc_pkg::adcsc_is_diff(chan_q);
    end

    // sequencer; dropping the enable aborts whatever is running
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_first = first;
        next_result = result;
        if (conv_enable_i && !en_q)
        begin
            next_first = 1'b1;
        end
        if (!conv_enable_i)
        begin
            next_state = adcsc_pkg::ST_IDLE;
            next_cnt = 4'h0;
        end
        else
        begin
            case (state)
                adcsc_pkg::ST_IDLE:
                begin
                    if (start_req)
                    begin
                        if (first || !en_q)
                        begin
                            next_state = adcsc_pkg::ST_INIT;
                            next_cnt = 4'(adcsc_pkg::FIRST_EXTRA_CYC - 4'h1);
                        end
                        else if (diff_now && clk2)
                        begin
                            next_state = adcsc_pkg::ST_SYNC;
                        end
                        else
                        begin
                            next_state = adcsc_pkg::ST_SAMPLE;
                            next_cnt = 4'(adcsc_pkg::SAMPLE_CYC - 4'h1);
                        end
                    end
                end
                adcsc_pkg::ST_INIT:
                begin
                    next_cnt = 4'(cnt - 4'h1);
                    if (cnt == 4'h0)
                    begin
                        next_first = 1'b0;
                        next_state = adcsc_pkg::ST_SAMPLE;
                        next_cnt = 4'(adcsc_pkg::SAMPLE_CYC - 4'h1);
                    end
                end
                adcsc_pkg::ST_SYNC:
                begin
                    // differential sampling waits so that it opens in the high half-rate phase
                    next_state = adcsc_pkg::ST_SAMPLE;
                    next_cnt = 4'(adcsc_pkg::SAMPLE_CYC - 4'h1);
                end
                adcsc_pkg::ST_SAMPLE:
                begin
                    next_cnt = 4'(cnt - 4'h1);
                    if (cnt == 4'h0)
                    begin
                        next_state = adcsc_pkg::ST_CONVERT;
                    end
                end
                adcsc_pkg::ST_CONVERT:
                begin
                    if (bus.sar_done)
                    begin
                        next_state = adcsc_pkg::ST_DONE;
                    end
                end
                adcsc_pkg::ST_DONE:
                begin
                    next_result = bus.mapped_code;
                    next_state = adcsc_pkg::ST_IDLE;
                end
                default:
                begin
                    next_state = adcsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // done flag: completion wins over a clear in the same cycle, and it is
    // raised whether or not the cpu already woke for something else
    always_comb
    begin
        next_done_flag = done_flag && !conv_done_clr_i;
        if (state == adcsc_pkg::ST_DONE && conv_enable_i)
        begin
            next_done_flag = 1'b1;
        end
    end

    // selections track software until a conversion locks them, and resume
    // tracking in the completing cycle
    always_comb
    begin
        next_ref = ref_q;
        next_chan = chan_q;
        if (state == adcsc_pkg::ST_IDLE || state == adcsc_pkg::ST_DONE)
        begin
            if (!start_req || state == adcsc_pkg::ST_DONE)
            begin
                next_ref = reference_select_i;
                next_chan = channel_gain_select_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= adcsc_pkg::ST_IDLE;
            cnt <= 4'h0;
            first <= 1'b1;
            en_q <= 1'b0;
            halt_q <= 1'b0;
            clk2 <= 1'b0;
            done_flag <= 1'b0;
            result <= adcsc_pkg::RESULT_RST;
            ref_q <= adcsc_pkg::REF_RST;
            chan_q <= adcsc_pkg::CHAN_RST;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            first <= next_first;
            en_q <= conv_enable_i;
            halt_q <= cpu_halted_i;
            clk2 <= ~clk2;
            done_flag <= next_done_flag;
            result <= next_result;
            ref_q <= next_ref;
            chan_q <= next_chan;
        end
    end

    // reference routing, one switch per source
    always_comb
    begin
        case (adcsc_pkg::adcsc_ref_e'(ref_q))
            adcsc_pkg::REF_EXT_PIN: ref_route_o = 4'h1;
            adcsc_pkg::REF_ANALOG_SUPPLY: ref_route_o = 4'h2;
            adcsc_pkg::REF_INT_1V1: ref_route_o = 4'h4;
            adcsc_pkg::REF_INT_2V56: ref_route_o = 4'h8;
            default: ref_route_o = 4'h1;
        endcase
    end

    // engine and formatter hookup
    assign bus.sar_start = (state == adcsc_pkg::ST_SAMPLE) && (cnt == 4'h0);
    assign bus.sar_abort = !conv_enable_i;
    assign bus.sar_cmp = cmp_i;
    assign bus.diff_sel = diff_now;
    assign bus.stored = result;
    assign bus.left_adj = result_left_adjust_i;

    // outputs; power follows the enable only, never the sleep state
    assign analog_on_o = conv_enable_i;
    assign sample_o = (state == adcsc_pkg::ST_SAMPLE);
    assign dac_code_o = bus.sar_trial;
    assign chan_sel_o = chan_q;
    assign conv_start_o = (state != adcsc_pkg::ST_IDLE);
    assign conv_done_flag_o = done_flag;
    assign conv_irq_o = done_flag && conv_done_ie_i;
    assign result_low_byte_o = bus.low_byte;
    assign result_high_byte_o = bus.high_byte;
    assign result_sign_bit_o = result[9];

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_armed_halt;
        conv_enable_i && single_mode_i && !conv_start_o && sleep_qual && halt_rise;
    endsequence

    sequence s_plain_start;
        start_req && !first && en_q && !(diff_now && clk2);
    endsequence

    sequence s_first_start;
        start_req && first;
    endsequence

    a_sleep_start: assert property (
        s_armed_halt |=> conv_start_o)
        else $error("halt in sleep did not start a conversion");
    a_other_sleep: assert property (
        (!conv_start_o && !sw_start && !sleep_qual) |=> !conv_start_o)
        else $error("conversion started in a wrong sleep state");
    a_no_restart: assert property (
        (!conv_start_o && halt_q && !sw_start) |=> !conv_start_o)
        else $error("conversion restarted without a new halt");
    a_normal_len: assert property (
        (s_plain_start ##1 conv_enable_i [*8] ##1 conv_enable_i [*5])
        |-> (conv_start_o ##1 !conv_start_o && conv_done_flag_o))
        else $error("normal conversion not thirteen cycles");
    a_first_len: assert property (
        s_first_start |-> ##25 (conv_start_o || !conv_enable_i)
        ##1 (!conv_start_o))
        else $error("first conversion not twenty-five cycles");
    a_write_zero: assert property (
        (conv_start_we_i && !conv_start_wd_i && !sleep_start && !conv_start_o)
        |=> !conv_start_o)
        else $error("writing zero started a conversion");
    a_flag_set_wins: assert property (
        (state == adcsc_pkg::ST_DONE && conv_enable_i && conv_done_clr_i)
        |=> conv_done_flag_o)
        else $error("completion lost against a clear");
    a_result_hold: assert property (
        (conv_done_flag_o && state != adcsc_pkg::ST_DONE) |=> $stable(result))
        else $error("result moved while flag held");
    a_left_shape: assert property (
        result_left_adjust_i |-> (result_high_byte_o == result[9:2]
        && result_low_byte_o[5:0] == 6'h00))
        else $error("left adjusted bytes wrong");
    a_sel_locked: assert property (
        (conv_start_o && state != adcsc_pkg::ST_DONE && $past(conv_start_o))
        |-> $stable(ref_q))
        else $error("reference changed during conversion");
endmodule : adcsc_top

// [adcsc_analog_model.sv]
// adcsc_analog_model: behavioural analog side, track-and-hold plus comparator.
// assumes the level is given by the bench as a raw offset-binary code.
`timescale 1ns/1ps
module adcsc_analog_model
(
    // clock
    input wire logic mclk_i,
    // from the converter controller
    input wire logic analog_on_i,
    input wire logic sample_i,
    input wire logic [9:0] dac_code_i,
    // analog level as a raw code
    input wire logic [9:0] level_i,
    // comparator answer
    output logic cmp_o
);
    logic [9:0] held = 10'h000;
    logic flip = 1'b0;

    // hold follows the level only while sampling, so later changes are not seen
    always_ff @(posedge mclk_i)
    begin
        flip <= ~flip;
        if (sample_i)
        begin
            held <= level_i;
        end
    end

    // unpowered comparator gives a changing answer, never a steady one
    assign cmp_o = analog_on_i ? (held >= dac_code_i) : flip;
endmodule : adcsc_analog_model

// [test_adc_sleep_conversion_result.sv]
// test_adc_sleep_conversion_result: directed bench for adcsc_top.
// assumes adcsc_analog_model stands on the analog side.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module test_adc_sleep_conversion_result;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic en = 1'b1, we = 1'b0, wd = 1'b0, single = 1'b1, ie = 1'b1, clr = 1'b0;
    logic left_adj = 1'b0, halted = 1'b0, cmp, analog_on, sample, conv_start, done, irq;
    logic [1:0] ref_sel = 2'h0;
    logic [4:0] chan = 5'h00, chan_q;
    logic [2:0] slp = 3'h0;
    logic [9:0] level = 10'h000, dac;
    logic [3:0] ref_route;
    logic [7:0] lo, hi;
    logic sign;
    int err_count = 0, checks = 0, cycles = 0, n;
    logic [9:0] diff_in [5] = '{10'h200, 10'h1ff, 10'h070, 10'h3ff, 10'h000};

    adcsc_top uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .conv_enable_i(en),
        .conv_start_we_i(we), .conv_start_wd_i(wd), .single_mode_i(single),
        .conv_done_ie_i(ie), .conv_done_clr_i(clr), .result_left_adjust_i(left_adj),
        .reference_select_i(ref_sel), .channel_gain_select_i(chan),
        .cpu_halted_i(halted), .sleep_mode_i(slp), .cmp_i(cmp), .analog_on_o(analog_on),
        .sample_o(sample), .dac_code_o(dac), .ref_route_o(ref_route), .chan_sel_o(chan_q),
        .conv_start_o(conv_start), .conv_done_flag_o(done), .conv_irq_o(irq),
        .result_low_byte_o(lo), .result_high_byte_o(hi), .result_sign_bit_o(sign));
    adcsc_analog_model model (.mclk_i(mclk_i), .analog_on_i(analog_on), .sample_i(sample),
        .dac_code_i(dac), .level_i(level), .cmp_o(cmp));

    // 200 MHz clock
    always #2.5 mclk_i = ~mclk_i;

    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // a hang counts as a mismatch and still ends in the report
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            summarize();
        end
    end

    // clear the flag, then write one to start
    task automatic start_conv(input logic [9:0] lvl);
        @(posedge mclk_i) clr <= 1'b1;
        level <= lvl;
        @(posedge mclk_i) clr <= 1'b0;
        we <= 1'b1;
        wd <= 1'b1;
        @(posedge mclk_i) we <= 1'b0;
        #1;
    endtask : start_conv

    // count busy cycles; bounded so a stuck busy cannot hang the run
    task automatic wait_done;
        n = 0;
        while (conv_start === 1'b1 && n < 60)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
    endtask : wait_done

    // look at the result both ways round
    task automatic chk_bytes(input logic [9:0] r);
        @(posedge mclk_i) left_adj <= 1'b0;
        #1;
        `CHK("low byte right", r[7:0], lo)
        `CHK("high byte right", {6'h00, r[9:8]}, hi)
        @(posedge mclk_i) left_adj <= 1'b1;
        #1;
        `CHK("high byte left", r[9:2], hi)
        `CHK("low byte left", {r[1:0], 6'h00}, lo)
        `CHK("sign bit", r[9], sign)
    endtask : chk_bytes

    // watch a stretch of cycles for any start
    task automatic quiet(input int len);
        repeat (len)
        begin
            @(posedge mclk_i);
            #1;
            `CHK("no start", 1'b0, conv_start)
        end
    endtask : quiet

    initial
    begin
        repeat (6) @(posedge mclk_i);
        nrst_i <= 1'b1;
        #1;
        `CHK("result after reset", 8'h00, lo)
        // reference select while idle, one-hot route
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk_i) ref_sel <= 2'(i);
            repeat (2) @(posedge mclk_i);
            #1;
            `CHK("reference route", 4'h1 << i, ref_route)
        end
        // writing zero leaves the converter idle
        @(posedge mclk_i) we <= 1'b1;
        @(posedge mclk_i) we <= 1'b0;
        quiet(3);
        // first conversion is long; full-scale single-ended code
        start_conv(10'h3ff);
        `CHK("busy readback", 1'b1, conv_start)
        wait_done();
        `CHK("first length", adcsc_pkg::FIRST_CONV_CYC, n)
        `CHK("done flag", 1'b1, done)
        chk_bytes(10'h3ff);
        // later conversion is normal; justification changes while busy
        start_conv(10'h2a5);
        `CHK("sampling", 1'b1, sample)
        chk_bytes(10'h3ff);
        wait_done();
        `CHK("normal length", adcsc_pkg::NORMAL_CONV_CYC - 2, n)
        `CHK("last trial", 10'h2a5, dac)
        chk_bytes(10'h2a5);
        start_conv(10'h000);
        wait_done();
        chk_bytes(10'h000);
        // differential pair gives two's complement codes
        @(posedge mclk_i) chan <= 5'h0d;
        for (int i = 0; i < 5; i++)
        begin
            start_conv(diff_in[i]);
            `CHK("channel lock", 5'h0d, chan_q)
            wait_done();
            chk_bytes(diff_in[i] ^ 10'h200);
        end
        // sleep start: armed, noise-reduction, halt rises
        @(posedge mclk_i) chan <= 5'h01;
        clr <= 1'b1;
        slp <= 3'b001;
        level <= 10'h155;
        @(posedge mclk_i) clr <= 1'b0;
        halted <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK("sleep start", 1'b1, conv_start)
        @(posedge mclk_i) halted <= 1'b0;
        #1;
        `CHK("busy after early wake", 1'b1, conv_start)
        wait_done();
        `CHK("wake request", 1'b1, irq)
        chk_bytes(10'h155);
        // idle sleep starts too; staying halted does not repeat
        @(posedge mclk_i) clr <= 1'b1;
        slp <= 3'b000;
        @(posedge mclk_i) clr <= 1'b0;
        halted <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK("idle sleep start", 1'b1, conv_start)
        wait_done();
        `CHK("wake request idle", 1'b1, irq)
        quiet(20);
        // other sleep states neither start nor power down
        @(posedge mclk_i) halted <= 1'b0;
        clr <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk_i) halted <= 1'b0;
            clr <= 1'b0;
            slp <= (i < 2) ? 3'(i + 2) : 3'(i + 4);
            @(posedge mclk_i) halted <= 1'b1;
            quiet(4);
            `CHK("power kept", 1'b1, analog_on)
        end
        `CHK("no wake request", 1'b0, irq)
        // dropping enable aborts a running conversion and leaves the flag clear
        start_conv(10'h0c0);
        @(posedge mclk_i) en <= 1'b0;
        @(posedge mclk_i);
        #1;
        `CHK("power off", 1'b0, analog_on)
        `CHK("aborted", 1'b0, conv_start)
        `CHK("no flag on abort", 1'b0, done)
        // off and on again before differential work gives the long conversion
        @(posedge mclk_i) en <= 1'b1;
        chan <= 5'h0d;
        start_conv(10'h0c0);
        wait_done();
        `CHK("extended length", adcsc_pkg::FIRST_CONV_CYC, n)
        chk_bytes(10'h2c0);
        summarize();
    end
endmodule : test_adc_sleep_conversion_result
